/* core/pps_prbs.v */
`timescale 1ns/1ps
`include "pps_defs.vh"
module pps_prbs
(
  input  wire        clk,
  input  wire        rst_n,
  input  wire        ce,
  input  wire        load,
  input  wire        step,
  input  wire [31:0] seed,
  input  wire [31:0] taps,
  output wire        bit_out
);
  reg  [31:0] lfsr_reg;
  wire        fb;

  // Fibonacci register: the parity of the tapped stages shifts in at stage 1.
  assign fb      = ^(lfsr_reg & taps);
  assign bit_out = fb;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      lfsr_reg <= `PPS_SEED_RESET;
    else if (ce)
    begin
      if (load)
        lfsr_reg <= (seed == 32'h0000_0000) ? `PPS_SEED_RESET : seed;  // R05
      else if (step)
        lfsr_reg <= {lfsr_reg[30:0], fb};  // R03
    end
  end
endmodule

/* core/pps_skid.v */
`timescale 1ns/1ps
module pps_skid
#(
  parameter WIDTH = 2
)
(
  input  wire             clk,
  input  wire             rst_n,
  input  wire             ce,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_reg [0:1];
  reg             wptr_reg;
  reg             rptr_reg;
  reg  [1:0]      cnt_reg;
  wire            push;
  wire            pop;

  assign in_ready  = (cnt_reg != 2'd2);
  assign out_valid = (cnt_reg != 2'd0);
  assign out_data  = mem_reg[rptr_reg];
  assign push      = in_valid & in_ready & ce;
  assign pop       = out_valid & out_ready & ce;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wptr_reg   <= 1'b0;
      rptr_reg   <= 1'b0;
      cnt_reg    <= 2'd0;
      mem_reg[0] <= {WIDTH{1'b0}};
      mem_reg[1] <= {WIDTH{1'b0}};
    end
    else
    begin
      if (push)
      begin
        mem_reg[wptr_reg] <= in_data;
        wptr_reg          <= ~wptr_reg;
      end
      if (pop)
        rptr_reg <= ~rptr_reg;
      if (push & ~pop)
        cnt_reg <= cnt_reg + 2'd1;
      else if (pop & ~push)
        cnt_reg <= cnt_reg - 2'd1;
    end
  end
endmodule

/* core/pps_source.v */
// What this block does
// R01: The four-level symbol mode runs only while two channels are combined; otherwise no symbols.
// R02: Normal polarity sends a one as high level, inverted_level sends a one as low level.
// R03: The pseudo-random source gives a maximal sequence of length 2^n-1, n from the eight sizes.
// R04: The sequence_complement switch inverts the pseudo-random bit stream when on.
// R05: The pseudo-random register starts from a programmable seed so lanes can differ in phase.
// R06: Gray mapping turns 00,01,10,11 into 00,01,11,10; with it off the binary pair passes.
// R07: The stored-pattern source builds the stream from a user pattern loaded into the block.
// R08: Choosing the stored-pattern source starts its load and a loading flag stays up meanwhile.
// R09: A custom tap mask gives any stage count and stored patterns serve as user sequences.
// R10: Two source bits form a symbol, then complement, then polarity, then Gray mapping apply.
`timescale 1ns/1ps
`include "pps_defs.vh"
module pps_source
#(
  parameter PAT_DEPTH = 256,
  parameter PAT_AW    = 8
)
(
  input  wire        clk,
  input  wire        rst_n,
  input  wire        ce,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg  [1:0]  sym_data,
  output reg         sym_valid,
  input  wire        sym_ready,
  output reg         loading
);
  // --------------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------------
  reg  [31:0]       ctrl_reg;
  reg  [31:0]       seed_reg;
  reg  [31:0]       poly_reg;
  reg  [PAT_AW:0]   pat_len_reg;
  reg  [PAT_AW-1:0] wr_ptr_reg;
  reg               pat_mem [0:PAT_DEPTH-1];
  reg  [31:0]       pat_buf_reg;
  reg  [5:0]        pat_cnt_reg;
  reg               aw_hold_reg;
  reg               w_hold_reg;
  reg  [7:0]        aw_addr_reg;
  reg  [31:0]       w_data_reg;
  reg  [3:0]        w_strb_reg;

  wire        enable   = ctrl_reg[`PPS_CTRL_ENABLE];
  wire        combined = ctrl_reg[`PPS_CTRL_COMBINED];
  wire        src_pat  = ctrl_reg[`PPS_CTRL_SOURCE];
  wire        compl    = ctrl_reg[`PPS_CTRL_COMPL];
  wire        inv_lvl  = ctrl_reg[`PPS_CTRL_INV_LVL];
  wire        gray     = ctrl_reg[`PPS_CTRL_GRAY];
  wire [2:0]  len_sel  = ctrl_reg[`PPS_CTRL_LEN_HI:`PPS_CTRL_LEN_LO];
  wire        pam_ok   = enable & combined;  // R01

  function [31:0] merge;
    input [31:0] old;
    input [31:0] val;
    input [3:0]  strb;
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1)
        merge[k*8 +: 8] = strb[k] ? val[k*8 +: 8] : old[k*8 +: 8];
    end
  endfunction

  function [31:0] taps_of;
    input [2:0]  sel;
    input [31:0] custom;
    begin
      if (custom != 32'h0000_0000)
        taps_of = custom;  // R09
      else
        case (sel)
          `PPS_LEN_7:  taps_of = `PPS_TAPS_7;
          `PPS_LEN_9:  taps_of = `PPS_TAPS_9;
          `PPS_LEN_10: taps_of = `PPS_TAPS_10;
          `PPS_LEN_11: taps_of = `PPS_TAPS_11;
          `PPS_LEN_15: taps_of = `PPS_TAPS_15;
          `PPS_LEN_20: taps_of = `PPS_TAPS_20;
          `PPS_LEN_23: taps_of = `PPS_TAPS_23;
          default:     taps_of = `PPS_TAPS_31;
        endcase
    end
  endfunction

  // --------------------------------------------------------------------------
  // AXI4-Lite write path
  // --------------------------------------------------------------------------
  wire       do_write  = aw_hold_reg & w_hold_reg & ~s_axi_bvalid;
  wire [7:0] wa        = aw_addr_reg;
  wire [31:0] wv_ctrl  = merge(ctrl_reg, w_data_reg, w_strb_reg);
  wire       start_load = do_write & (wa == `PPS_ADDR_CTRL) &
                          wv_ctrl[`PPS_CTRL_SOURCE] & ~src_pat;
  wire       pat_wr    = do_write & (wa == `PPS_ADDR_PAT_DATA) & loading;
  wire       restart;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PPS_RESP_OKAY;
      aw_hold_reg   <= 1'b0;
      w_hold_reg    <= 1'b0;
      aw_addr_reg   <= 8'h00;
      w_data_reg    <= 32'h0000_0000;
      w_strb_reg    <= 4'h0;
      ctrl_reg      <= `PPS_CTRL_RESET;
      seed_reg      <= `PPS_SEED_RESET;
      poly_reg      <= 32'h0000_0000;
      pat_len_reg   <= {(PAT_AW+1){1'b0}};
      loading       <= 1'b0;
      wr_ptr_reg    <= {PAT_AW{1'b0}};
    end
    else if (ce)
    begin
      s_axi_awready <= ~aw_hold_reg & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_hold_reg & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (do_write)
      begin
        aw_hold_reg  <= 1'b0;
        w_hold_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `PPS_RESP_OKAY;
        case (wa)
          `PPS_ADDR_CTRL:     ctrl_reg <= wv_ctrl;
          `PPS_ADDR_SEED:     seed_reg <= merge(seed_reg, w_data_reg, w_strb_reg);  // R05
          `PPS_ADDR_POLY:     poly_reg <= merge(poly_reg, w_data_reg, w_strb_reg);  // R09
          `PPS_ADDR_PAT_LEN:  pat_len_reg <= w_data_reg[PAT_AW:0];
          `PPS_ADDR_PAT_DATA: ;
          default:            s_axi_bresp <= `PPS_RESP_SLVERR;
        endcase
      end
      // Loading begins when the stored source is chosen and ends after the last bit lands.
      if (start_load)
      begin
        loading    <= 1'b1;  // R08
        wr_ptr_reg <= {PAT_AW{1'b0}};
      end
      else if (pat_wr)
      begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
        if ({1'b0, wr_ptr_reg} + 1'b1 >= pat_len_reg)
          loading <= 1'b0;  // R08
      end
      else if (loading & ~src_pat)
        loading <= 1'b0;
    end
  end

  // One stored-pattern bit per data write keeps the memory a plain bit array.
  always @(posedge clk)
  begin
    if (ce & pat_wr)
      pat_mem[wr_ptr_reg] <= w_data_reg[0];  // R07
  end

  // --------------------------------------------------------------------------
  // AXI4-Lite read path
  // --------------------------------------------------------------------------
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `PPS_RESP_OKAY;
    end
    else if (ce)
    begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_rvalid & s_axi_rready)
        s_axi_rvalid <= 1'b0;
      if (s_axi_arvalid & s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `PPS_RESP_OKAY;
        case (s_axi_araddr)
          `PPS_ADDR_CTRL:    s_axi_rdata <= ctrl_reg;
          `PPS_ADDR_SEED:    s_axi_rdata <= seed_reg;
          `PPS_ADDR_POLY:    s_axi_rdata <= poly_reg;
          `PPS_ADDR_STATUS:  s_axi_rdata <= {30'h0, pam_ok, loading};
          `PPS_ADDR_PAT_LEN: s_axi_rdata <= {{(31-PAT_AW){1'b0}}, pat_len_reg};
          default:
          begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `PPS_RESP_SLVERR;
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // Bit source and symbol builder
  // --------------------------------------------------------------------------
  reg  [PAT_AW-1:0] rd_ptr_reg;
  reg               half_reg;
  reg               first_reg;
  wire              prbs_bit;
  wire              fifo_ready;
  wire              fifo_valid;
  wire [1:0]        fifo_data;
  wire              run      = pam_ok & ~loading &
                               (~src_pat | (pat_len_reg != {(PAT_AW+1){1'b0}}));
  wire              take_bit = run & (~half_reg | fifo_ready);
  wire              src_bit  = src_pat ? pat_mem[rd_ptr_reg] : (prbs_bit ^ compl);  // R04 R07
  wire              lvl_bit  = src_bit ^ inv_lvl;  // R02
  wire [1:0]        pair     = {first_reg, lvl_bit};
  wire [1:0]        mapped   = gray ? {pair[1], pair[1] ^ pair[0]} : pair;  // R06
  wire              push     = take_bit & half_reg;

  // Any write to the control or seed register reloads the seed so lanes restart in phase.
  assign restart = do_write & ((wa == `PPS_ADDR_CTRL) | (wa == `PPS_ADDR_SEED));

  pps_prbs u_prbs
  (
    .clk     (clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .load    (restart),
    .step    (take_bit & ~src_pat),
    .seed    (seed_reg),
    .taps    (taps_of(len_sel, poly_reg)),
    .bit_out (prbs_bit)
  );

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_ptr_reg <= {PAT_AW{1'b0}};
      half_reg   <= 1'b0;
      first_reg  <= 1'b0;
    end
    else if (ce)
    begin
      if (restart | ~run)
      begin
        rd_ptr_reg <= {PAT_AW{1'b0}};
        half_reg   <= 1'b0;
      end
      else if (take_bit)
      begin
        half_reg  <= ~half_reg;  // R10
        first_reg <= lvl_bit;
        if (src_pat)
          rd_ptr_reg <= ({1'b0, rd_ptr_reg} + 1'b1 >= pat_len_reg) ?
                        {PAT_AW{1'b0}} : rd_ptr_reg + 1'b1;
      end
    end
  end

  // The buffer absorbs one stall cycle so no symbol is lost behind the output stage.
  pps_skid #(.WIDTH(2)) u_skid
  (
    .clk       (clk),
    .rst_n     (rst_n),
    .ce        (ce),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   (mapped),
    .out_valid (fifo_valid),
    .out_ready (~sym_valid | sym_ready),
    .out_data  (fifo_data)
  );

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sym_valid <= 1'b0;
      sym_data  <= 2'b00;
    end
    else if (ce & (~sym_valid | sym_ready))
    begin
      sym_valid <= fifo_valid & pam_ok;  // R01
      sym_data  <= fifo_data;
    end
  end
endmodule

/* inc/pps_defs.vh */
`ifndef PPS_DEFS_VH
`define PPS_DEFS_VH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define PPS_ADDR_CTRL      8'h00
`define PPS_ADDR_SEED     8'h04
`define PPS_ADDR_POLY     8'h08
`define PPS_ADDR_STATUS   8'h0C
`define PPS_ADDR_PAT_LEN  8'h10
`define PPS_ADDR_PAT_DATA 8'h14

// ----------------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------------
`define PPS_CTRL_ENABLE   0
`define PPS_CTRL_COMBINED 1
`define PPS_CTRL_SOURCE   2
`define PPS_CTRL_COMPL    3
`define PPS_CTRL_INV_LVL  4
`define PPS_CTRL_GRAY     5
`define PPS_CTRL_RESTART  6
`define PPS_CTRL_LEN_LO   8
`define PPS_CTRL_LEN_HI   10
`define PPS_CTRL_RESET    32'h0000_0000

// ----------------------------------------------------------------------------
// Sequence length codes
// ----------------------------------------------------------------------------
`define PPS_LEN_7      3'h0
`define PPS_LEN_9      3'h1
`define PPS_LEN_10     3'h2
`define PPS_LEN_11     3'h3
`define PPS_LEN_15     3'h4
`define PPS_LEN_20     3'h5
`define PPS_LEN_23     3'h6
`define PPS_LEN_31     3'h7

// Feedback taps, bit k set means stage k+1 feeds back.
`define PPS_TAPS_7     32'h0000_0060
`define PPS_TAPS_9     32'h0000_0110
`define PPS_TAPS_10    32'h0000_0240
`define PPS_TAPS_11    32'h0000_0500
`define PPS_TAPS_15    32'h0000_6000
`define PPS_TAPS_20    32'h0008_0004
`define PPS_TAPS_23    32'h0042_0000
`define PPS_TAPS_31    32'h4800_0000
`define PPS_SEED_RESET 32'h7FFF_FFFF

// ----------------------------------------------------------------------------
// Status fields and bus responses
// ----------------------------------------------------------------------------
`define PPS_STAT_LOADING  0
`define PPS_STAT_PAM_OK   1
`define PPS_RESP_OKAY     2'h0
`define PPS_RESP_SLVERR   2'h2

`endif

/* tb/pps_monitor.sv */
`timescale 1ns/1ps
`include "pps_defs.vh"
module pps_monitor
(
  input logic        clk,
  input logic        rst_n,
  input logic [7:0]  s_axi_awaddr,
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic [1:0]  s_axi_bresp,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic [1:0]  sym_data,
  input logic        sym_valid,
  input logic        sym_ready,
  input logic        loading
);
  // ----------
  // Control shadow
  // ----------
  // The bench offers address and data together, so one edge takes both.
  logic [31:0] ctrl_q;
  logic [7:0]  aw_q;
  logic [1:0]  exp_bresp;

  // Status is read-only, so a write to it is answered with an error like an unmapped one.
  assign exp_bresp = (aw_q <= `PPS_ADDR_PAT_DATA && aw_q[1:0] == 2'h0 &&
                      aw_q != `PPS_ADDR_STATUS) ? `PPS_RESP_OKAY : `PPS_RESP_SLVERR;

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      ctrl_q <= 32'h0000_0000;
      aw_q   <= 8'h00;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
        aw_q <= s_axi_awaddr;
      if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
          && s_axi_awaddr == `PPS_ADDR_CTRL)
        ctrl_q <= s_axi_wdata;
    end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_reset_quiet: assert property ($rose(rst_n) |-> !s_axi_bvalid && !sym_valid && !loading)
    else $error("output busy after reset");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_b_time: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:3] s_axi_bvalid) else $error("write response late");
  a_r_time: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  a_bresp_code: assert property (s_axi_bvalid |-> s_axi_bresp == exp_bresp)
    else $error("wrong write response");
  a_sym_hold: assert property (sym_valid && !sym_ready |=> sym_valid && $stable(sym_data))
    else $error("symbol changed while stalled");
  a_pam_gate: assert property ((!ctrl_q[0] || !ctrl_q[1]) [*8] |-> !sym_valid)
    else $error("symbol without combined mode");
  a_load_start: assert property ($rose(ctrl_q[2]) |-> ##[0:3] loading)
    else $error("load did not start");
  a_load_quiet: assert property (loading [*3] |-> !sym_valid)
    else $error("symbol during load");
endmodule

bind pps_source pps_monitor pps_monitor_i (.*);

/* tb/pps_sink.sv */
`timescale 1ns/1ps
module pps_sink
(
  input  logic       clk,
  input  logic       rst_n,
  input  logic [1:0] sym_data,
  input  logic       sym_valid,
  input  logic [1:0] mode,
  output logic       sym_ready
);
  // Mode 0 takes every cycle, 1 every other cycle, 2 stalls outright.
  logic [1:0] got[$];

  always @(posedge clk or negedge rst_n)
    if (!rst_n)
      sym_ready <= 1'b0;
    else
    begin
      if (sym_valid && sym_ready)
        got.push_back(sym_data);
      sym_ready <= mode == 2'h2 ? 1'b0 : mode == 2'h1 ? !sym_ready : 1'b1;
    end
endmodule

/* tb/pps_source_tb_top.sv */
`timescale 1ns/1ps
`include "pps_defs.vh"
module pps_source_tb_top;
  logic        clk = 1'b0, rst_n = 1'b0, ce = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, pat = 8'hb2;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, sym_data, mode = 2'h0, e;
  logic        sym_valid, sym_ready, loading;
  logic [1:0]  q[$], base[$];
  int          fails = 0, checks = 0;

  pps_source pps_source_i (.*);
  pps_sink pps_sink_i (.clk(clk), .rst_n(rst_n), .sym_data(sym_data), .sym_valid(sym_valid),
                       .mode(mode), .sym_ready(sym_ready));

  always #2.5 clk = ~clk;

  // ----------
  // Shared tasks
  // ----------
  task automatic close_out();
    if (fails == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic tmo();
    fails++;
    $display("[ERR] %0t wait ran out", $time);
    close_out();
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checks++;
    if (g !== x)
    begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, g, x);
    end
  endtask

  // Response code 3 is never sent, so it marks a response that is not judged.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 100 && !(s_axi_bvalid && !s_axi_awvalid && !s_axi_wvalid); n++)
    begin
      @(posedge clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    if (n == 100)
      tmo();
    if (er != 2'h3)
      chk(s_axi_bresp, er);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] x, input logic [1:0] er);
    int n;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 100 && !s_axi_rvalid; n++)
    begin
      @(posedge clk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    if (n == 100)
      tmo();
    chk(s_axi_rdata, x);
    chk(s_axi_rresp, er);
  endtask

  // Disabling first lets the buffer drain, so the capture starts at the seed.
  task automatic run(input logic [31:0] c, input int n, input logic [1:0] m);
    int t;
    wr(`PPS_ADDR_CTRL, c & 32'hffff_fffe, 2'h0);
    repeat (12) @(posedge clk);
    pps_sink_i.got.delete();
    wr(`PPS_ADDR_CTRL, c, 2'h0);
    mode <= m;
    if (m == 2'h2)
    begin
      repeat (30) @(posedge clk);
      mode <= 2'h0;
    end
    for (t = 0; t < 20000 && pps_sink_i.got.size() < n; t++)
      @(posedge clk);
    mode <= 2'h0;
    if (t == 20000)
      tmo();
    q = pps_sink_i.got;
  endtask

  function automatic int same(input int n);
    same = 0;
    for (int i = 0; i < n; i++)
      same += (q[i] === base[i]);
  endfunction

  // With the clock enable low the running stream must stand still on its current symbol.
  task automatic freeze();
    logic [1:0] s;
    ce <= 1'b0;
    @(posedge clk);
    s = sym_data;
    repeat (10)
    begin
      @(posedge clk);
      chk(sym_data, s);
      chk(sym_valid, 1'b1);
    end
    ce <= 1'b1;
  endtask

  // A run of 2^n-1 bits holds 2^(n-1) ones; as symbols, p symbols hold p+1 ones.
  task automatic period(input int code, input int p);
    int ones;
    run(32'h0000_0003 | (code << 8), 2 * p + 8, 2'h0);
    ones = 0;
    for (int i = 0; i < p; i++)
      ones += q[i][1] + q[i][0];
    chk(ones, p + 1);
    for (int i = 0; i < 8; i++)
      chk(q[i + p], q[i]);
  endtask

  // ----------
  // Scenarios
  // ----------
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(`PPS_ADDR_CTRL, `PPS_CTRL_RESET, `PPS_RESP_OKAY);
    rdchk(`PPS_ADDR_SEED, `PPS_SEED_RESET, `PPS_RESP_OKAY);
    rdchk(`PPS_ADDR_STATUS, 32'h0000_0000, `PPS_RESP_OKAY);
    rdchk(8'h40, 32'h0000_0000, `PPS_RESP_SLVERR);
    wr(8'h40, 32'h0000_0005, `PPS_RESP_SLVERR);
    for (int k = 3; k >= 0; k--)
      period(k, (2 << (k == 0 ? 6 : k + 7)) - 1);
    base = q;
    for (int k = 1; k < 8; k++)
    begin
      run(32'h0000_0003 | (k << 3), 64, k == 1 ? 2'h1 : k == 2 ? 2'h2 : 2'h0);
      for (int i = 0; i < 64; i++)
      begin
        e = base[i] ^ {2{k[0] ^ k[1]}};
        e[0] = e[0] ^ (k[2] & e[1]);
        chk(q[i], e);
      end
    end
    for (int k = 4; k < 8; k++)
    begin
      run(32'h0000_0003 | (k << 8), 32, 2'h0);
      chk(same(32) < 32, 1);
    end
    wr(`PPS_ADDR_POLY, `PPS_TAPS_7, 2'h0);
    run(32'h0000_0703, 64, 2'h0);
    chk(same(64), 64);
    wr(`PPS_ADDR_POLY, 32'h0000_0000, 2'h0);
    wr(`PPS_ADDR_SEED, 32'h0000_1234, 2'h0);
    run(32'h0000_0003, 64, 2'h0);
    chk(same(64) < 64, 1);
    wr(`PPS_ADDR_SEED, 32'h0000_0000, 2'h0);
    run(32'h0000_0003, 64, 2'h0);
    chk(same(64), 64);
    wr(`PPS_ADDR_CTRL, 32'h0000_0000, 2'h0);
    repeat (12) @(posedge clk);
    pps_sink_i.got.delete();
    wr(`PPS_ADDR_CTRL, 32'h0000_0001, 2'h0);
    repeat (40) @(posedge clk);
    chk(pps_sink_i.got.size(), 0);
    rdchk(`PPS_ADDR_STATUS, 32'h0000_0000, `PPS_RESP_OKAY);
    wr(`PPS_ADDR_CTRL, 32'h0000_0000, 2'h0);
    wr(`PPS_ADDR_PAT_LEN, 32'h0000_0008, 2'h0);
    wr(`PPS_ADDR_CTRL, 32'h0000_0007, 2'h0);
    rdchk(`PPS_ADDR_STATUS, 32'h0000_0003, `PPS_RESP_OKAY);
    for (int i = 0; i < 8; i++)
      wr(`PPS_ADDR_PAT_DATA, {31'h0, pat[7 - i]}, 2'h0);
    rdchk(`PPS_ADDR_STATUS, 32'h0000_0002, `PPS_RESP_OKAY);
    wr(`PPS_ADDR_PAT_DATA, 32'h0000_0001, `PPS_RESP_OKAY);
    for (int v = 0; v < 2; v++)
    begin
      run(32'h0000_0007 | (v << 4), 16, 2'h0);
      for (int i = 0; i < 16; i++)
        chk(q[i], pat[7 - 2 * (i % 4) -: 2] ^ {2{v[0]}});
    end
    freeze();
    close_out();
  end
endmodule
